// ===== src/status_codes_pkg.sv
// status_codes_pkg: response and reason code values, command types and
// the request/answer carriers of the sideband status encoder.
// assumes: one clock domain, synchronous active-high reset.
package status_codes_pkg;
   localparam logic [15:0] RESP_COMPLETED   = 16'h0000;
   localparam logic [15:0] RESP_FAILED      = 16'h0001;
   localparam logic [15:0] RESP_UNAVAILABLE = 16'h0002;
   localparam logic [15:0] RESP_UNSUPPORTED = 16'h0003;
   localparam logic [15:0] RESP_DELAYED     = 16'h0004;
   localparam logic [15:0] RESP_VENDOR_BASE = 16'h8000;

   localparam logic [15:0] RSN_NONE         = 16'h0000;
   localparam logic [15:0] RSN_INIT_REQ     = 16'h0001;
   localparam logic [15:0] RSN_PARAM_BAD    = 16'h0002;
   localparam logic [15:0] RSN_CHAN_BUSY    = 16'h0003;
   localparam logic [15:0] RSN_PKG_BUSY     = 16'h0004;
   localparam logic [15:0] RSN_LEN_BAD      = 16'h0005;
   localparam logic [15:0] RSN_NO_INFO      = 16'h0006;
   localparam logic [15:0] RSN_INTERVENE    = 16'h0007;
   localparam logic [15:0] RSN_CMD_UNKNOWN  = 16'h7FFF;
   localparam logic [15:0] RSN_MAC_ZERO     = 16'h0E08;
   localparam logic [7:0]  VENDOR_LOW_BASE  = 8'h80;

   localparam logic [7:0]  CMD_CLEAR_INIT   = 8'h00;
   localparam logic [7:0]  CMD_PKG_SELECT   = 8'h01;
   localparam logic [7:0]  CMD_PKG_DESELECT = 8'h02;

   localparam int          DEADLINE_MS      = 1000;
   localparam int          CLK_HZ           = 50000000;
   localparam int          CYCLES_PER_MS    = CLK_HZ / 1000;
   localparam int          DEADLINE_CYCLES  = DEADLINE_MS * CYCLES_PER_MS;

   // condition flags reported by the command handler
   typedef struct packed {
      logic       supported;
      logic       pkg_intervene;
      logic       pkg_busy;
      logic       chan_busy;
      logic       len_bad;
      logic       param_bad;
      logic       no_info;
      logic       failed;
      logic       unavailable;
      logic       mac_zero;
      logic       vendor_resp;
      logic       vendor_rsn;
      logic       specific_rsn;
   } cmd_flags_t;

   typedef struct packed {
      logic [7:0]  cmd_type;
      cmd_flags_t  flags;
      logic [14:0] vendor_resp_low;
      logic [6:0]  rsn_low;
   } cmd_req_t;

   typedef struct packed {
      logic [15:0] resp_code;
      logic [15:0] rsn_code;
      logic [15:0] poll_ms;
      logic        delayed;
   } status_word_t;
endpackage

// ===== src/response_status_encoder.sv
// response_status_encoder: picks the response and reason codes for each
// command, tracks the channel initial state, and the final-answer deadline.
// assumes: the command handler presents one request per req_valid pulse and
// raises done_valid when execution finishes; one clock, sync reset.
`timescale 1ns/1ns
module response_status_encoder
   import status_codes_pkg::*;
#(
   parameter int DEADLINE_COUNT = DEADLINE_CYCLES
) (
   input  wire logic                     clk,
   input  wire logic                     sys_rst,
   input  wire logic                     req_valid,
   input  wire status_codes_pkg::cmd_req_t req,
   input  wire logic                     done_valid,
   input  wire logic [15:0]              poll_estimate_ms,
   output logic                          ans_valid,
   output status_codes_pkg::status_word_t ans,
   output logic [31:0]                   default_word,
   output logic                          busy,
   output logic                          initial_state
);
   import status_codes_pkg::*;

   typedef enum logic [1:0] {IDLE, RUNNING} state_t;

   state_t      state;
   cmd_req_t    held;
   logic [31:0] deadline_cnt;
   logic        deadline_hit;
   status_word_t next_ans;
   cmd_flags_t  f;
   logic        sel_cmd;
   logic        is_clear;
   logic [15:0] specific_code;
   logic        specific_ok;
   logic [15:0] vendor_rsn_code;
   logic        finish;
   logic        timeout;

   assign f        = held.flags;
   assign sel_cmd  = (held.cmd_type == CMD_PKG_SELECT) ||
                     (held.cmd_type == CMD_PKG_DESELECT);
   assign is_clear = held.cmd_type == CMD_CLEAR_INIT;
   // command-specific reasons carry the command type in the upper byte
   assign specific_code = {held.cmd_type, 1'b0, held.rsn_low};
   assign specific_ok   = held.cmd_type != CMD_CLEAR_INIT;
   // generic vendor reasons keep a zero upper byte
   assign vendor_rsn_code = {8'h00, VENDOR_LOW_BASE | {1'b0, held.rsn_low}};
   assign deadline_hit = deadline_cnt >= 32'(DEADLINE_COUNT - 1);
   assign finish  = (state == RUNNING) && done_valid;
   assign timeout = (state == RUNNING) && !done_valid && deadline_hit;
   assign busy    = state == RUNNING;

   always_comb begin
      next_ans = '{resp_code: RESP_COMPLETED, rsn_code: RSN_NONE,
                   poll_ms: 16'h0000, delayed: 1'b0};
      if (f.pkg_intervene && !sel_cmd) begin
         // validity checks are skipped, no command payload follows
         next_ans.resp_code = RESP_UNAVAILABLE;
         next_ans.rsn_code  = RSN_INTERVENE;
      end else if (!f.supported) begin
         next_ans.resp_code = RESP_UNSUPPORTED;
         next_ans.rsn_code  = RSN_CMD_UNKNOWN;
      end else if (initial_state && !sel_cmd && !is_clear) begin
         next_ans.resp_code = RESP_FAILED;
         next_ans.rsn_code  = RSN_INIT_REQ;
      end else if (f.pkg_busy) begin
         next_ans.resp_code = RESP_UNAVAILABLE;
         next_ans.rsn_code  = RSN_PKG_BUSY;
      end else if (f.chan_busy) begin
         next_ans.resp_code = RESP_UNAVAILABLE;
         next_ans.rsn_code  = RSN_CHAN_BUSY;
      end else if (f.len_bad) begin
         next_ans.resp_code = RESP_FAILED;
         next_ans.rsn_code  = RSN_LEN_BAD;
      end else if (f.param_bad) begin
         next_ans.resp_code = RESP_FAILED;
         next_ans.rsn_code  = RSN_PARAM_BAD;
      end else if (f.no_info) begin
         next_ans.resp_code = RESP_FAILED;
         next_ans.rsn_code  = RSN_NO_INFO;
      end else if (f.unavailable) begin
         next_ans.resp_code = RESP_UNAVAILABLE;
         next_ans.rsn_code  = RSN_NONE;
      end else if (f.failed) begin
         next_ans.resp_code = RESP_FAILED;
         next_ans.rsn_code  = RSN_NONE;
      end else if (f.mac_zero) begin
         next_ans.rsn_code  = RSN_MAC_ZERO;
      end
      // vendor detail may replace the standard response and reason when no fixed pair
      if (f.supported && !(f.pkg_intervene && !sel_cmd) &&
          !(initial_state && !sel_cmd && !is_clear)) begin
         if (f.vendor_resp)
            next_ans.resp_code = RESP_VENDOR_BASE |
                                 {1'b0, held.vendor_resp_low};
         if (f.specific_rsn && specific_ok)
            next_ans.rsn_code = specific_code;
         else if (f.vendor_rsn)
            next_ans.rsn_code = vendor_rsn_code;
      end
      if (timeout) begin
         next_ans.resp_code = RESP_DELAYED;
         next_ans.rsn_code  = RSN_NONE;
         next_ans.poll_ms   = poll_estimate_ms;
         next_ans.delayed   = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state <= IDLE;
         held  <= '0;
      end else if (state == IDLE && req_valid) begin
         state <= RUNNING;
         held  <= req;
      end else if (finish || timeout) begin
         state <= IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || state != RUNNING)
         deadline_cnt <= '0;
      else
         deadline_cnt <= deadline_cnt + 32'h00000001;
   end

   // channel leaves the initial state once the clear command completes
   always_ff @(posedge clk) begin
      if (sys_rst)
         initial_state <= 1'b1;
      else if (finish && is_clear && f.supported &&
               !(f.pkg_intervene) && next_ans.resp_code == RESP_COMPLETED)
         initial_state <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ans_valid    <= 1'b0;
         ans          <= '0;
         default_word <= '0;
      end else begin
         ans_valid <= finish || timeout;
         if (finish || timeout) begin
            ans          <= next_ans;
            // response code in the upper half, reason code below
            default_word <= {next_ans.resp_code,
                             next_ans.rsn_code};
         end
      end
   end
endmodule // response_status_encoder

// ===== tb/status_encoder_properties.sv
// checker: answer codes and answer timing of the status encoder
// assumes: bound into response_status_encoder, one clock, sync reset
`timescale 1ns/1ns
module status_encoder_properties
   import status_codes_pkg::*;
#(parameter int DEADLINE_COUNT = 20) (
   input wire logic                           clk,
   input wire logic                           sys_rst,
   input wire logic                           req_valid,
   input wire status_codes_pkg::cmd_req_t     req,
   input wire logic                           done_valid,
   input wire logic                           ans_valid,
   input wire status_codes_pkg::status_word_t ans,
   input wire logic [31:0]                    default_word,
   input wire logic                           busy,
   input wire logic                           initial_state
);
   cmd_req_t cap;
   int       cnt;
   wire      norm = ans_valid && !ans.delayed;
   wire      ok   = cap.flags.supported && !cap.flags.pkg_intervene;
   always_ff @(posedge clk) begin
      if (req_valid && !busy) cap <= req;
      cnt <= busy ? cnt + 1 : 0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_done; busy && done_valid; endsequence
   sequence s_ans; ans_valid && !busy; endsequence
   word_order_a: assert property (
      ans_valid |-> default_word == {ans.resp_code, ans.rsn_code})
      else $error("default word differs from codes");
   done_ans_a: assert property (s_done |=> s_ans)
      else $error("no answer after done");
   unknown_pair_a: assert property (
      ans_valid && ans.rsn_code == RSN_CMD_UNKNOWN |-> ans.resp_code == 16'h3)
      else $error("unknown reason without unsupported");
   delayed_pair_a: assert property (
      ans_valid && ans.delayed |-> ans.resp_code == RESP_DELAYED &&
      ans.rsn_code == RSN_NONE && $past(cnt) >= DEADLINE_COUNT - 2)
      else $error("bad delayed answer");
   unsupported_a: assert property (
      norm && !cap.flags.pkg_intervene && !cap.flags.supported |->
      default_word == 32'h0003_7FFF) else $error("bad unsupported answer");
   intervene_a: assert property (
      norm && cap.flags.pkg_intervene && cap.cmd_type > 8'h02 |->
      ans.rsn_code == RSN_INTERVENE) else $error("bad intervention answer");
   init_block_a: assert property (
      norm && ok && initial_state && cap.cmd_type > 8'h02 |->
      ans.rsn_code == RSN_INIT_REQ) else $error("initial state not reported");
   init_clear_a: assert property (
      $fell(initial_state) |-> ans_valid && cap.cmd_type == CMD_CLEAR_INIT)
      else $error("initial state left without clear");
endmodule // status_encoder_properties
bind response_status_encoder status_encoder_properties #(.DEADLINE_COUNT(
   DEADLINE_COUNT)) u_props (.clk(clk), .sys_rst(sys_rst), .req(req),
   .req_valid(req_valid), .done_valid(done_valid), .ans_valid(ans_valid),
   .ans(ans), .default_word(default_word), .busy(busy),
   .initial_state(initial_state));

// ===== tb/cmd_handler_model.sv
// cmd_handler_model: far-side handler, ends each running command that the deadline has not ended first
// assumes: pulses done_valid once, lat+1 cycles after busy rises
`timescale 1ns/1ns
module cmd_handler_model (
   input  wire logic        clk,
   input  wire logic        busy,
   input  wire logic [15:0] lat,
   output logic             done_valid
);
   logic [15:0] n;
   always_ff @(posedge clk) begin
      n          <= busy ? n + 16'h1 : 16'h0;
      done_valid <= busy && (n == lat);
   end
endmodule // cmd_handler_model

// ===== tb/tb_top.sv
// tb_top: self-checking bench for the response status encoder
// assumes: checker bound by its own file, handler model ends commands except in t_delay
`timescale 1ns/1ns
module tb_top;
   import status_codes_pkg::*;
   logic         clk = 0, sys_rst = 1, req_valid = 0;
   logic         done_valid, ans_valid, busy, initial_state;
   cmd_req_t     req = '0;
   status_word_t ans;
   logic [31:0]  default_word;
   logic [15:0]  poll_estimate_ms = 16'h0123, lat = 16'h0003;
   int           n_fail = 0, comparisons = 0, cyc = 0;
   always #10 clk = ~clk;
   response_status_encoder #(.DEADLINE_COUNT(20)) u_dut (.clk(clk),
      .sys_rst(sys_rst), .req_valid(req_valid), .req(req), .busy(busy),
      .done_valid(done_valid), .poll_estimate_ms(poll_estimate_ms),
      .ans_valid(ans_valid), .ans(ans), .default_word(default_word),
      .initial_state(initial_state));
   cmd_handler_model u_peer (.clk(clk), .busy(busy), .lat(lat),
      .done_valid(done_valid));
   task automatic give_verdict;
      if (n_fail == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic run(input logic [7:0] c, input logic [12:0] f,
         input logic [14:0] v, input logic [6:0] r, input logic [31:0] e);
      @(posedge clk) #2;
      req_valid = 1;
      req = {c, f, v, r};
      @(posedge clk) #2;
      req_valid = 0;
      for (int i = 0; i < 60 && ans_valid !== 1'b1; i++) @(posedge clk) #1;
      chk(default_word, e);
   endtask
   task automatic t_init;
      chk({31'h0, initial_state}, 32'h1);
      run(8'h05, 13'h1000, 15'h0, 7'h0, 32'h0001_0001);
      run(8'h01, 13'h1000, 15'h0, 7'h0, 32'h0);
      run(8'h00, 13'h1000, 15'h0, 7'h0, 32'h0);
      chk({31'h0, initial_state}, 32'h0);
      chk({31'h0, busy}, 32'h0);
   endtask
   task automatic t_delay;
      lat = 16'h00C8;
      for (int k = 0; k < 2; k++) begin
         run(8'h0A, 13'h1000, 15'h0, 7'h0, 32'h0004_0000);
         chk({15'h0, ans.delayed, ans.poll_ms},
             {16'h1, poll_estimate_ms});
         poll_estimate_ms = 16'h0;
      end
      lat = 16'h0003;
   endtask
   task automatic t_reasons;
      run(8'h05, 13'h0000, 15'h0, 7'h0, 32'h0003_7FFF);
      run(8'h05, 13'h1800, 15'h0, 7'h0, 32'h0002_0007);
      run(8'h02, 13'h1800, 15'h0, 7'h0, 32'h0);
      run(8'h05, 13'h1400, 15'h0, 7'h0, 32'h0002_0004);
      run(8'h05, 13'h1200, 15'h0, 7'h0, 32'h0002_0003);
      run(8'h05, 13'h1100, 15'h0, 7'h0, 32'h0001_0005);
      run(8'h05, 13'h1080, 15'h0, 7'h0, 32'h0001_0002);
      run(8'h05, 13'h1040, 15'h0, 7'h0, 32'h0001_0006);
      run(8'h05, 13'h1020, 15'h0, 7'h0, 32'h0001_0000);
      run(8'h05, 13'h1010, 15'h0, 7'h0, 32'h0002_0000);
      run(8'h05, 13'h1008, 15'h0, 7'h0, 32'h0000_0E08);
      run(8'h0A, 13'h1005, 15'h1234, 7'h05, 32'h9234_0A05);
      run(8'h00, 13'h1003, 15'h0, 7'h05, 32'h0000_0085);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #2 sys_rst = 0;
      t_init();
      t_delay();
      t_reasons();
      give_verdict();
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         give_verdict();
      end
   end
endmodule // tb_top
